// File: rtl/ldc_top.sv
// second LED drive configuration register bank with current target outputs
//
// What this block does
// - bit 13 set full strength, clear low power
// - scale is 0.4 plus 0.6 times strength bit
// - bits 6..4 slew rate, 0 slowest, 7 fastest
// - bits 3..0 coarse current sink target code
// - peak is coarse times fine times scale
// - coarse equals 28 plus 15.46 times code mA
// - fine equals 0.71 plus 0.024 times code
// - fine code in bits 10..6, resets 0xC
// - table: 25 mA at 0, 250 at 15
`timescale 1ns/1ps
`default_nettype none

module ldc_top
	import ldc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	output logic             second_led_strength_select,
	output logic             second_led_low_power,
	output logic      [2:0]  second_led_edge_rate,
	output logic      [3:0]  second_led_coarse_current,
	output logic      [4:0]  second_led_fine_code,
	output logic      [7:0]  second_led_coarse_table_ma,
	output logic      [15:0] second_led_coarse_x100,
	output logic      [10:0] second_led_fine_multiplier,
	output logic      [3:0]  second_led_scale_x10,
	output logic      [18:0] second_led_peak_ua
);

	logic        rst_meta;
	logic        rst_n;
	logic [15:0] drive_reg;
	logic [15:0] fine_reg;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	// assert at once, release two edges later so no flop sees a runt release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	// reserved bits are kept as written; the host owns their values
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_reg <= LDC_RESET_DRIVE;
		end else if (reg_wr && reg_addr == LDC_ADDR_DRIVE) begin
			drive_reg <= reg_wdata;
		end
	end

	// adjacent fine register; only the second LED field is used here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fine_reg <= LDC_RESET_FINE;
		end else if (reg_wr && reg_addr == LDC_ADDR_FINE) begin
			fine_reg <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// a read in the same cycle as a write returns the old contents
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					LDC_ADDR_DRIVE: begin
						reg_rdata <= drive_reg;
					end
					LDC_ADDR_FINE: begin
						reg_rdata <= fine_reg;
					end
					default: begin
						reg_rdata <= LDC_READ_UNMAPPED;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// driver controls
	// ----------------------------------------------------------------
	// decoded fields follow the register one edge later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			second_led_strength_select <= 1'b0;
			second_led_low_power       <= 1'b0;
			second_led_edge_rate       <= 3'h0;
			second_led_coarse_current  <= 4'h0;
			second_led_fine_code       <= 5'h00;
		end else begin
			second_led_strength_select <= drive_reg[LDC_STRENGTH_BIT];
			second_led_low_power       <= !drive_reg[LDC_STRENGTH_BIT];
			second_led_edge_rate       <= drive_reg[LDC_EDGE_LSB +: LDC_EDGE_W];
			second_led_coarse_current  <= drive_reg[LDC_COARSE_LSB +: LDC_COARSE_W];
			second_led_fine_code       <= fine_reg[LDC_FINE_LSB +: LDC_FINE_W];
		end
	end

	// ----------------------------------------------------------------
	// current target arithmetic
	// ----------------------------------------------------------------
	ldc_calc u_calc (
		.clk         (clk),
		.rst_n       (rst_n),
		.strength    (second_led_strength_select),
		.coarse_code (second_led_coarse_current),
		.fine_code   (second_led_fine_code),
		.coarse_x100 (second_led_coarse_x100),
		.fine_x1000  (second_led_fine_multiplier),
		.scale_x10   (second_led_scale_x10),
		.table_ma    (second_led_coarse_table_ma),
		.peak_ua     (second_led_peak_ua)
	);

endmodule

`default_nettype wire

// File: common/ldc_pkg.sv
// package: register map, field layout, reset values and current-formula constants
package ldc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  LDC_ADDR_DRIVE   = 8'h24;
	localparam logic [7:0]  LDC_ADDR_FINE    = 8'h25;
	localparam logic [15:0] LDC_RESET_DRIVE  = 16'h3000;
	localparam logic [15:0] LDC_RESET_FINE   = 16'h630C;
	localparam logic [15:0] LDC_READ_UNMAPPED = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LDC_STRENGTH_BIT  = 13;
	localparam int LDC_EDGE_LSB      = 4;
	localparam int LDC_EDGE_W        = 3;
	localparam int LDC_COARSE_LSB    = 0;
	localparam int LDC_COARSE_W      = 4;
	localparam int LDC_FINE_LSB      = 6;
	localparam int LDC_FINE_W        = 5;

	// ----------------------------------------------------------------
	// current formula, fixed point
	// ----------------------------------------------------------------
	// coarse in units of 0.01 mA: 28 + 15.46 * code
	localparam logic [15:0] LDC_COARSE_BASE = 16'h0AF0;
	localparam logic [15:0] LDC_COARSE_STEP = 16'h060A;
	// fine in units of 0.001: 0.71 + 0.024 * code
	localparam logic [10:0] LDC_FINE_BASE   = 11'h2C6;
	localparam logic [10:0] LDC_FINE_STEP   = 11'h018;
	// scale in units of 0.1: 0.4 or 1.0
	localparam logic [3:0]  LDC_SCALE_LOW   = 4'h4;
	localparam logic [3:0]  LDC_SCALE_FULL  = 4'hA;
	// table in mA: 25 + 15 * code
	localparam logic [7:0]  LDC_TABLE_BASE  = 8'h19;
	localparam logic [7:0]  LDC_TABLE_STEP  = 8'h0F;
	// 1e-6 mA product to microamperes
	localparam logic [31:0] LDC_PEAK_DIV    = 32'h0000_03E8;

endpackage

// File: rtl/ldc_calc.sv
// peak current target arithmetic for the second LED driver
`timescale 1ns/1ps
`default_nettype none

module ldc_calc
	import ldc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        strength,
	input  wire logic [3:0]  coarse_code,
	input  wire logic [4:0]  fine_code,
	output logic      [15:0] coarse_x100,
	output logic      [10:0] fine_x1000,
	output logic      [3:0]  scale_x10,
	output logic      [7:0]  table_ma,
	output logic      [18:0] peak_ua
);

	logic [31:0] product;

	// ----------------------------------------------------------------
	// stage one: the three factors
	// ----------------------------------------------------------------
	// all factors from one edge so the product never mixes old and new codes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			coarse_x100 <= 16'h0000;
			fine_x1000  <= 11'h000;
			scale_x10   <= 4'h0;
			table_ma    <= 8'h00;
		end else begin
			coarse_x100 <= LDC_COARSE_BASE + LDC_COARSE_STEP * {12'h000, coarse_code};
			fine_x1000  <= LDC_FINE_BASE + LDC_FINE_STEP * {6'h00, fine_code};
			scale_x10   <= strength ? LDC_SCALE_FULL : LDC_SCALE_LOW;
			table_ma    <= LDC_TABLE_BASE + LDC_TABLE_STEP * {4'h0, coarse_code};
		end
	end

	// ----------------------------------------------------------------
	// stage two: peak product
	// ----------------------------------------------------------------
	// product tops out near 3.8e8, well inside 32 bits
	always_comb begin
		product = {16'h0000, coarse_x100} * {21'h000000, fine_x1000} * {28'h0000000, scale_x10};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			peak_ua <= 19'h00000;
		end else begin
			peak_ua <= 19'(product / LDC_PEAK_DIV);
		end
	end

endmodule

`default_nettype wire

// File: tb/ldc_chk_sva.sv
// checker: port assertions for the second LED drive register bank
`timescale 1ns/1ps
`default_nettype none
module ldc_chk
	import ldc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        second_led_strength_select,
	input wire logic        second_led_low_power,
	input wire logic [2:0]  second_led_edge_rate,
	input wire logic [3:0]  second_led_coarse_current,
	input wire logic [4:0]  second_led_fine_code,
	input wire logic [15:0] second_led_coarse_x100,
	input wire logic [10:0] second_led_fine_multiplier,
	input wire logic [3:0]  second_led_scale_x10,
	input wire logic [18:0] second_led_peak_ua
);
	// ------------------------------------------------
	// warm-up: internal reset lags rstn by two edges
	// ------------------------------------------------
	logic [2:0] up;
	logic       en;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) up <= 3'h0;
		else if (up != 3'h7) up <= up + 3'h1;
	end
	assign en = (up == 3'h7);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_wr(a);
		en ##0 (reg_wr && reg_addr == a);
	endsequence
	property p_low; en |-> second_led_low_power == !second_led_strength_select; endproperty
	property p_scale; en |=> second_led_scale_x10 ==
		($past(second_led_strength_select) ? 4'hA : 4'h4); endproperty
	// register lands at the write edge, decoded field one edge later
	property p_edge; s_wr(LDC_ADDR_DRIVE) |=> ##1
		second_led_edge_rate == $past(reg_wdata[6:4], 2); endproperty
	property p_coarse; s_wr(LDC_ADDR_DRIVE) |=> ##1
		second_led_coarse_current == $past(reg_wdata[3:0], 2); endproperty
	property p_fcode; s_wr(LDC_ADDR_FINE) |=> ##1
		second_led_fine_code == $past(reg_wdata[10:6], 2); endproperty
	property p_cx; en |=> second_led_coarse_x100 ==
		16'h0AF0 + 16'h060A * $past(second_led_coarse_current); endproperty
	property p_fine; en |=> second_led_fine_multiplier ==
		11'h2C6 + 11'h018 * $past(second_led_fine_code); endproperty
	property p_peak; en |=> 32'(second_led_peak_ua) == (32'($past(second_led_coarse_x100)) *
		$past(second_led_fine_multiplier) * $past(second_led_scale_x10)) / 32'd1000; endproperty
	a_low: assert property (p_low) else $error("low power not inverse of strength");
	a_scale: assert property (p_scale) else $error("scale wrong");
	a_edge: assert property (p_edge) else $error("edge rate wrong");
	a_coarse: assert property (p_coarse) else $error("coarse code wrong");
	a_fcode: assert property (p_fcode) else $error("fine code wrong");
	a_cx: assert property (p_cx) else $error("coarse value wrong");
	a_fine: assert property (p_fine) else $error("fine multiplier wrong");
	a_peak: assert property (p_peak) else $error("peak wrong");
endmodule
bind ldc_top ldc_chk ldc_chk_i (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
	.second_led_strength_select, .second_led_low_power, .second_led_edge_rate,
	.second_led_coarse_current, .second_led_fine_code, .second_led_coarse_x100,
	.second_led_fine_multiplier, .second_led_scale_x10, .second_led_peak_ua);
`default_nettype wire

// File: tb/ldc_host.sv
// host model: register writes and reads, one strobe per access
`timescale 1ns/1ps
`default_nettype none
module ldc_host (
	input  wire logic        clk,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid,
	output logic      [7:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// reserved bits of the drive word forced to their fixed values
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = (a == 8'h24) ? {2'b00, d[13], 1'b1, 5'b0_0000, d[6:0]} : d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata; // released bus shows garbage
	endtask
	// answer is registered at the edge that takes the strobe and sampled at the next falling edge
	task automatic rd(input logic [7:0] a, output logic [15:0] q, output logic v);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		q = reg_rdata;
		v = reg_rvalid;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_ldc_top.sv
// testbench: random drive settings checked against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_ldc_top;
	logic clk = 1'b0, rstn = 1'b0, reg_wr, reg_rd, reg_rvalid, v;
	logic [7:0] reg_addr, second_led_coarse_table_ma;
	logic [15:0] reg_wdata, reg_rdata, second_led_coarse_x100, q, drv, fin;
	logic second_led_strength_select, second_led_low_power;
	logic [2:0] second_led_edge_rate;
	logic [3:0] second_led_coarse_current, second_led_scale_x10;
	logic [4:0] second_led_fine_code;
	logic [10:0] second_led_fine_multiplier;
	logic [18:0] second_led_peak_ua;
	int n_mismatch = 0, checks_done = 0, seed = 32'h8960f99e;
	always #4 clk = ~clk;
	ldc_top ldc_top_i (.*);
	ldc_host ldc_host_i (.*);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ------------------------------------------------
	// reference model of all driver outputs
	// ------------------------------------------------
	task automatic chk_out();
		int c, f, s, cx, fx;
		c = drv[3:0];
		f = fin[10:6];
		s = drv[13] ? 10 : 4;
		cx = 2800 + 1546 * c;
		fx = 710 + 24 * f;
		chk("strength", second_led_strength_select, drv[13]);
		chk("low_power", second_led_low_power, !drv[13]);
		chk("scale", second_led_scale_x10, s);
		chk("edge", second_led_edge_rate, drv[6:4]);
		chk("coarse", second_led_coarse_current, c);
		chk("fine_code", second_led_fine_code, f);
		chk("coarse_x100", second_led_coarse_x100, cx);
		chk("fine", second_led_fine_multiplier, fx);
		chk("table", second_led_coarse_table_ma, 25 + 15 * c);
		chk("peak", second_led_peak_ua, cx * fx * s / 1000);
		ldc_host_i.rd(8'h24, q, v);
		chk("rd_drive", {v, q}, {1'b1, drv});
		ldc_host_i.rd(8'h25, q, v);
		chk("rd_fine", {v, q}, {1'b1, fin});
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		drv = 16'h3000;
		fin = 16'h630C;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		chk_out();
		ldc_host_i.rd(8'h26, q, v);
		chk("rd_unmapped", {v, q}, 17'h10000);
		for (int i = 0; i < 40; i++) begin
			drv = $random(seed);
			drv = {2'b00, drv[13], 6'b10_0000, drv[6:4], (i == 0) ? 4'hF : drv[3:0]};
			fin = $random(seed);
			ldc_host_i.wr(8'h24, drv);
			ldc_host_i.wr(8'h25, fin);
			ldc_host_i.wr(8'h26, ~drv);
			repeat (4) @(negedge clk);
			chk_out();
		end
		complete_run();
	end
endmodule
`default_nettype wire
